// ### verilog/rcr_recorder.sv
// Reset cause recorder: combines the reset sources into one internal
// reset, records the cause flags and hosts the supply monitor controls.
// Assumes a byte-wide CPU memory bus on CLK, analog comparator outputs
// and the reset pin arriving asynchronously, watchdog request on CLK.
`timescale 1ns/1ps
`default_nettype none
`include "rcr_regs.svh"

module rcr_recorder
   import rcr_pkg::*;
(
   // Clock and power-on reset
   input  wire logic        CLK,
   input  wire logic        RESETN,
   // CPU memory bus, byte wide
   input  wire logic [15:0] BUS_ADDR,
   input  wire logic        BUS_RD,
   input  wire logic        BUS_WR,
   input  wire logic [7:0]  BUS_WDATA,
   output var  logic [7:0]  BUS_RDATA,
   // Reset sources
   input  wire logic        EXT_RESET_N,
   input  wire logic        POC_SUPPLY_LOW,
   input  wire logic        WDT_RESET_REQ,
   input  wire logic        MON_SUPPLY_LOW,
   // Supply monitor comparator controls
   output var  logic        MON_ENABLE,
   output var  logic [3:0]  MON_LEVEL,
   // Results
   output var  logic        SUPPLY_LOW_IRQ,
   output var  logic        INT_RESET_N
);

   // Least reset width in cycles, rounded up
   localparam int HOLD_CYC =
      (`RCR_RST_HOLD_NS + `RCR_CLK_PERIOD_NS - 1) / `RCR_CLK_PERIOD_NS;
   localparam logic [7:0] HOLD_LOAD = 8'(HOLD_CYC - 1);

   rcr_state_t  state_reg;
   rcr_state_t  state_next;
   logic [7:0]  hold_cnt_reg;
   rcr_src_t    src;
   rcr_flags_t  flags_reg;
   logic        ext_n_s;
   logic        poc_low_s;
   logic        mon_low_s;
   logic        any_req;
   logic        bus_ok;
   logic        rd_cause;
   logic        wr_ctrl;
   logic        wr_level;
   logic        ctrl_clear;
   logic        mon_en_reg;
   logic        mon_mode_reg;
   logic [3:0]  mon_level_reg;
   logic        low_flag;
   logic [7:0]  rdata_next;

   // Outside levels pass the filtered three-stage chain
   rcr_pin_sync #(.RESET_VAL(1'b1)) u_sync_ext (
      .clk   (CLK),
      .rst_n (RESETN),
      .din   (EXT_RESET_N),
      .dout  (ext_n_s)
   );
   // Supply assumed low until the comparator says otherwise
   rcr_pin_sync #(.RESET_VAL(1'b1)) u_sync_poc (
      .clk   (CLK),
      .rst_n (RESETN),
      .din   (POC_SUPPLY_LOW),
      .dout  (poc_low_s)
   );
   rcr_pin_sync #(.RESET_VAL(1'b0)) u_sync_mon (
      .clk   (CLK),
      .rst_n (RESETN),
      .din   (MON_SUPPLY_LOW),
      .dout  (mon_low_s)
   );

   // Monitor output; the comparator level through the CLK-clocked chain,
   // gated by the enable flop, which the pin, power-on and watchdog resets clear
   assign low_flag = mon_en_reg & mon_low_s;

   // Gather the reset requests into one carrier
   always_comb begin
      src.ext = ~ext_n_s;
      src.power_on_clear_unit = poc_low_s;
      src.wdt = WDT_RESET_REQ;
      src.low = low_flag & mon_mode_reg;
   end
   assign any_req = |src;

   // Reset sequencer: power on, hold while requested, then release
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         RCR_ST_POWERUP: begin
            if (!any_req && hold_cnt_reg == 8'h00)
               state_next = RCR_ST_RUN;
         end
         RCR_ST_RUN: begin
            if (any_req)
               state_next = RCR_ST_HOLD;
         end
         RCR_ST_HOLD: begin
            if (!any_req && hold_cnt_reg == 8'h00)
               state_next = RCR_ST_RUN;
         end
         default: begin
            state_next = RCR_ST_POWERUP;
         end
      endcase
   end

   // Power on starts in reset with the hold count loaded
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_reg <= RCR_ST_POWERUP;
      end else begin
         state_reg <= state_next;
      end
   end

   // Hold counter reloads on every request so short glitches still
   // give a full-width internal reset
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         hold_cnt_reg <= HOLD_LOAD;
      end else if (any_req) begin
         hold_cnt_reg <= HOLD_LOAD;
      end else if (hold_cnt_reg != 8'h00) begin
         hold_cnt_reg <= hold_cnt_reg - 8'h01;
      end
   end

   assign INT_RESET_N = (state_reg == RCR_ST_RUN);

   // Bus answers only while the CPU is out of reset
   assign bus_ok   = (state_reg == RCR_ST_RUN);
   assign rd_cause = bus_ok & BUS_RD & (BUS_ADDR == `RCR_ADDR_CAUSE);
   assign wr_ctrl  = bus_ok & BUS_WR & (BUS_ADDR == `RCR_ADDR_MON_CTRL);
   assign wr_level = bus_ok & BUS_WR & (BUS_ADDR == `RCR_ADDR_MON_LEVEL);

   // Cause flags: pin and power-on-clear clear both, a source sets its
   // own and a read clears, but a set in the same cycle wins
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         flags_reg <= '0;
      end else if (src.ext || src.power_on_clear_unit) begin
         flags_reg <= '0;
      end else begin
         flags_reg.wdt <= src.wdt |
                          (flags_reg.wdt & ~rd_cause);
         flags_reg.low <= src.low |
                          (flags_reg.low & ~rd_cause);
      end
   end

   // Monitor settings survive its own reset, cleared by the others
   assign ctrl_clear = src.ext | src.power_on_clear_unit | src.wdt;

   // Monitor enable and mode select
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         mon_en_reg   <= `RCR_MON_EN_RESET;
         mon_mode_reg <= `RCR_MON_MODE_RESET;
      end else if (ctrl_clear) begin
         mon_en_reg   <= `RCR_MON_EN_RESET;
         mon_mode_reg <= `RCR_MON_MODE_RESET;
      end else if (wr_ctrl) begin
         mon_en_reg   <= BUS_WDATA[`RCR_MON_EN_BIT];
         mon_mode_reg <= BUS_WDATA[`RCR_MON_MODE_BIT];
      end
   end

   // Level select; an illegal code is dropped, not stored
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         mon_level_reg <= `RCR_LEVEL_RESET;
      end else if (ctrl_clear) begin
         mon_level_reg <= `RCR_LEVEL_RESET;
      end else if (wr_level && BUS_WDATA[7:4] == 4'h0 &&
                   BUS_WDATA[3:0] <= `RCR_LEVEL_MAX) begin
         mon_level_reg <= BUS_WDATA[3:0];
      end
   end

   assign MON_ENABLE = mon_en_reg;
   assign MON_LEVEL  = mon_level_reg;

   // Interrupt only in enabled interrupt mode
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         SUPPLY_LOW_IRQ <= 1'b0;
      end else begin
         SUPPLY_LOW_IRQ <= low_flag & ~mon_mode_reg;
      end
   end

   // Read data mux; unmapped addresses read zero
   always_comb begin
      rdata_next = `RCR_BYTE_ZERO;
      case (BUS_ADDR)
         `RCR_ADDR_CAUSE: begin
            rdata_next[`RCR_CAUSE_WDT_BIT] = flags_reg.wdt;
            rdata_next[`RCR_CAUSE_LOW_BIT] = flags_reg.low;
         end
         `RCR_ADDR_MON_CTRL: begin
            rdata_next[`RCR_MON_EN_BIT]   = mon_en_reg;
            rdata_next[`RCR_MON_MODE_BIT] = mon_mode_reg;
            rdata_next[`RCR_MON_LOW_BIT]  = low_flag;
         end
         `RCR_ADDR_MON_LEVEL: begin
            rdata_next[3:0] = mon_level_reg;
         end
         default: begin
            rdata_next = `RCR_BYTE_ZERO;
         end
      endcase
   end

   // Read data is captured before the read clear takes effect
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         BUS_RDATA <= `RCR_BYTE_ZERO;
      end else if (bus_ok && BUS_RD) begin
         BUS_RDATA <= rdata_next;
      end
   end

   // Checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);

   property p_read_clears;
      rd_cause && !src.wdt && !src.low && !src.ext && !src.power_on_clear_unit
         |=> flags_reg == 2'b00;
   endproperty
   a_read_clears: assert property (p_read_clears)
      else $error("cause flags not cleared by read");

   property p_ext_clears;
      src.ext |=> flags_reg == 2'b00 && !INT_RESET_N;
   endproperty
   a_ext_clears: assert property (p_ext_clears)
      else $error("pin reset did not clear flags");

   property p_poc_clears;
      src.power_on_clear_unit |=> flags_reg == 2'b00 && !INT_RESET_N;
   endproperty
   a_poc_clears: assert property (p_poc_clears)
      else $error("power-on-clear reset did not clear flags");

   property p_wdt_sets;
      src.wdt && !src.ext && !src.power_on_clear_unit |=> flags_reg.wdt;
   endproperty
   a_wdt_sets: assert property (p_wdt_sets)
      else $error("watchdog flag not set");

   property p_low_sets;
      src.low && !src.ext && !src.power_on_clear_unit |=> flags_reg.low && !INT_RESET_N;
   endproperty
   a_low_sets: assert property (p_low_sets)
      else $error("low supply flag not set");

   property p_wdt_keeps_low;
      src.wdt && !src.ext && !src.power_on_clear_unit && !src.low && !rd_cause
         |=> flags_reg.low == $past(flags_reg.low);
   endproperty
   a_wdt_keeps_low: assert property (p_wdt_keeps_low)
      else $error("watchdog reset disturbed the low supply flag");

   property p_write_ignored;
      BUS_WR && BUS_ADDR == `RCR_ADDR_CAUSE && !any_req && !rd_cause
         |=> $stable(flags_reg);
   endproperty
   a_write_ignored: assert property (p_write_ignored)
      else $error("write changed the cause register");

   property p_irq_mode;
      mon_en_reg && mon_low_s
         |=> SUPPLY_LOW_IRQ == !$past(mon_mode_reg);
   endproperty
   a_irq_mode: assert property (p_irq_mode)
      else $error("interrupt does not follow mode select");

   property p_release;
      (!any_req) [*5] |-> INT_RESET_N;
   endproperty
   a_release: assert property (p_release)
      else $error("internal reset not released after hold");

   property p_level_legal;
      wr_level && !ctrl_clear &&
         (BUS_WDATA[7:4] != 4'h0 || BUS_WDATA[3:0] > `RCR_LEVEL_MAX)
         |=> $stable(mon_level_reg);
   endproperty
   a_level_legal: assert property (p_level_legal)
      else $error("illegal level write changed the monitor level");

   c_wdt_read: cover property (flags_reg.wdt ##[1:50] rd_cause);
   c_low_reset: cover property (src.low ##1 flags_reg.low);
   c_irq: cover property (SUPPLY_LOW_IRQ);
   c_poc: cover property (src.power_on_clear_unit ##[1:50] INT_RESET_N);

endmodule : rcr_recorder
`default_nettype wire

// ### verilog/rcr_regs.svh
// Register map, bit positions, reset values and timing counts of the
// reset cause recorder. Assumes a byte-wide internal memory bus.
`ifndef RCR_REGS_SVH
`define RCR_REGS_SVH

// Byte addresses on the internal memory bus
`define RCR_ADDR_MON_CTRL    16'hff50
`define RCR_ADDR_MON_LEVEL   16'hff51
`define RCR_ADDR_CAUSE       16'hff54

// Reset cause flag layout
`define RCR_CAUSE_LOW_BIT    0
`define RCR_CAUSE_WDT_BIT    4

// Supply monitor control layout
`define RCR_MON_LOW_BIT      0
`define RCR_MON_MODE_BIT     1
`define RCR_MON_EN_BIT       7

// Level select: ten legal settings, 0 to 9
`define RCR_LEVEL_MAX        4'h9
`define RCR_LEVEL_RESET      4'h0

// Reset values
`define RCR_BYTE_ZERO        8'h00
`define RCR_MON_MODE_RESET   1'b0
`define RCR_MON_EN_RESET     1'b0

// Least internal reset width and the clock period
`define RCR_RST_HOLD_NS      100
`define RCR_CLK_PERIOD_NS    25

`endif

// ### verilog/rcr_pkg.sv
// Types shared by the reset cause recorder modules.
// Assumes the constants of rcr_regs.svh for addresses and fields.
package rcr_pkg;

   // Reset sequencer: powering up, running, held in reset; one bit
   // flips on each step of power up, run, hold and back to run
   typedef enum logic [1:0] {
      RCR_ST_POWERUP = 2'b00,
      RCR_ST_RUN     = 2'b01,
      RCR_ST_HOLD    = 2'b11
   } rcr_state_t;

   // Reset requests of the four sources, all active high
   typedef struct packed {
      logic ext;
      logic power_on_clear_unit;
      logic wdt;
      logic low;
   } rcr_src_t;

   // The two recorded cause flags
   typedef struct packed {
      logic wdt;
      logic low;
   } rcr_flags_t;

endpackage : rcr_pkg

// ### verilog/rcr_pin_sync.sv
// Three-stage synchroniser for one level arriving from outside CLK.
// Assumes the input may change at any time; output follows once the
// second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module rcr_pin_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Level in and filtered level out
   input  wire logic din,
   output var  logic dout
);

   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   // Shift chain; the first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= RESET_VAL;
         s2_reg <= RESET_VAL;
         s3_reg <= RESET_VAL;
      end else begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // A change counts only when two settled stages agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dout <= RESET_VAL;
      end else if (s2_reg == s3_reg) begin
         dout <= s3_reg;
      end
   end

endmodule : rcr_pin_sync
`default_nettype wire

// ### verif/rcr_supply_model.sv
// Far side model: supply rail with the power-on and monitor comparators,
// and a watchdog that holds its request until the reset is taken.
// Assumes the bench sets the rail in millivolts and fires the watchdog.
`timescale 1ns/1ps
`default_nettype none
module rcr_supply_model (
   // Clock and internal reset
   input  wire logic        clk,
   input  wire logic        int_reset_n,
   // Rail and watchdog trigger from the bench
   input  wire logic [15:0] supply_mv,
   input  wire logic        wdt_fire,
   // Monitor controls from the recorder
   input  wire logic        mon_enable,
   input  wire logic [3:0]  mon_level,
   // Comparator outputs and watchdog request
   output var  logic        poc_low,
   output var  logic        mon_low,
   output var  logic        wdt_req
);
   // Monitor trip points in millivolts, codes 0 to 9
   int lvl_mv [0:9];
   initial lvl_mv = '{4300, 4100, 3900, 3700, 3500,
                      3300, 3100, 2850, 2600, 2350};

   // Power-on comparator, high while the rail is under its threshold
   assign poc_low = supply_mv < 16'd2100;

   // A stopped comparator reports no low supply
   assign mon_low = mon_enable && (mon_level <= 4'h9) &&
                    (supply_mv < lvl_mv[mon_level]);

   // Request stays up until the internal reset removes it
   always_ff @(posedge clk) begin
      if (!int_reset_n)
         wdt_req <= 1'b0;
      else if (wdt_fire)
         wdt_req <= 1'b1;
   end
endmodule : rcr_supply_model
`default_nettype wire

// ### verif/rcr_recorder_tb_top.sv
// Self-checking bench of the reset cause recorder.
// Assumes the recorder, its package and register header are compiled.
`timescale 1ns/1ps
`default_nettype none
`include "rcr_regs.svh"
module rcr_recorder_tb_top;
   import rcr_pkg::*;
   logic        CLK, RESETN, BUS_RD, BUS_WR, EXT_RESET_N, wdt_fire;
   logic [15:0] BUS_ADDR, supply;
   logic [7:0]  BUS_WDATA, BUS_RDATA;
   logic [3:0]  MON_LEVEL;
   logic        POC_SUPPLY_LOW, WDT_RESET_REQ, MON_SUPPLY_LOW;
   logic        MON_ENABLE, SUPPLY_LOW_IRQ, INT_RESET_N;
   int          mismatches, tests_run, cycles, i;

   rcr_recorder dut (.CLK(CLK), .RESETN(RESETN), .BUS_ADDR(BUS_ADDR),
      .BUS_RD(BUS_RD), .BUS_WR(BUS_WR), .BUS_WDATA(BUS_WDATA),
      .BUS_RDATA(BUS_RDATA), .EXT_RESET_N(EXT_RESET_N),
      .POC_SUPPLY_LOW(POC_SUPPLY_LOW), .WDT_RESET_REQ(WDT_RESET_REQ),
      .MON_SUPPLY_LOW(MON_SUPPLY_LOW), .MON_ENABLE(MON_ENABLE),
      .MON_LEVEL(MON_LEVEL), .SUPPLY_LOW_IRQ(SUPPLY_LOW_IRQ),
      .INT_RESET_N(INT_RESET_N));

   rcr_supply_model far (.clk(CLK), .int_reset_n(INT_RESET_N),
      .supply_mv(supply), .wdt_fire(wdt_fire), .mon_enable(MON_ENABLE),
      .mon_level(MON_LEVEL), .poc_low(POC_SUPPLY_LOW),
      .mon_low(MON_SUPPLY_LOW), .wdt_req(WDT_RESET_REQ));

   // 40 MHz clock
   initial begin
      CLK = 1'b0;
      forever #12.5 CLK = ~CLK;
   end

   task automatic end_sim;
      $display("tests_run %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim

   // Hang guard, the sequence needs well under 3000 cycles
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         end_sim();
      end
   end

   task automatic chk(input string nm, input logic [7:0] s, e);
      tests_run++;
      if (s !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   // Inputs always move 2 ns after the rising edge
   task automatic cyc(input int n);
      repeat (n) begin
         @(posedge CLK);
         #2;
      end
   endtask : cyc

   // Byte write; the idle cycle keeps back-to-back strobes apart
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      BUS_ADDR = a;
      BUS_WDATA = d;
      BUS_WR = 1'b1;
      cyc(1);
      BUS_WR = 1'b0;
      cyc(1);
   endtask : wr

   // Whole-byte read only, never a single bit
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      BUS_ADDR = a;
      BUS_RD = 1'b1;
      cyc(1);
      BUS_RD = 1'b0;
      cyc(1);
      chk($sformatf("rdata %h", a), BUS_RDATA, e);
   endtask : rd

   // Internal reset must fall within a few cycles of a request
   task automatic lo;
      for (int k = 0; k < 10 && INT_RESET_N !== 1'b0; k++)
         cyc(1);
      chk("int_reset_n low", {7'h00, INT_RESET_N}, 8'h00);
   endtask : lo

   // Wait for release, then let the rail settle before any access
   task automatic rel;
      for (int k = 0; k < 40 && INT_RESET_N !== 1'b1; k++)
         cyc(1);
      chk("int_reset_n high", {7'h00, INT_RESET_N}, 8'h01);
      cyc(4);
   endtask : rel

   // Watchdog fires once and the reset runs its course
   task automatic wdt;
      wdt_fire = 1'b1;
      cyc(1);
      wdt_fire = 1'b0;
      lo();
      rel();
   endtask : wdt

   // Main sequence
   initial begin
      {BUS_RD, BUS_WR, wdt_fire, RESETN} = 4'h0;
      {BUS_ADDR, BUS_WDATA} = 24'h000000;
      EXT_RESET_N = 1'b1;
      supply = 16'd1500;
      cyc(16);
      RESETN = 1'b1;
      cyc(20);
      chk("power-on reset", {7'h00, INT_RESET_N}, 8'h00);
      supply = 16'd5000;
      rel();
      rd(`RCR_ADDR_CAUSE, 8'h00);
      rd(16'hff55, 8'h00);
      wr(`RCR_ADDR_CAUSE, 8'hff);
      rd(`RCR_ADDR_CAUSE, 8'h00);
      for (i = 0; i < 10; i++) begin
         wr(`RCR_ADDR_MON_LEVEL, 8'(i));
         rd(`RCR_ADDR_MON_LEVEL, 8'(i));
         chk("mon_level", {4'h0, MON_LEVEL}, 8'(i));
      end
      wr(`RCR_ADDR_MON_LEVEL, 8'h0a);
      rd(`RCR_ADDR_MON_LEVEL, 8'h09);
      wdt();
      rd(`RCR_ADDR_CAUSE, 8'h10);
      rd(`RCR_ADDR_CAUSE, 8'h00);
      // Watchdog flag left set, then the monitor resets the chip
      wdt();
      wr(`RCR_ADDR_MON_LEVEL, 8'h09);
      wr(`RCR_ADDR_MON_CTRL, 8'h82);
      supply = 16'd2300;
      lo();
      cyc(10);
      chk("held while low", {7'h00, INT_RESET_N}, 8'h00);
      chk("mon_enable kept", {7'h00, MON_ENABLE}, 8'h01);
      chk("mon_level kept", {4'h0, MON_LEVEL}, 8'h09);
      supply = 16'd5000;
      rel();
      // A watchdog reset now must keep the pending low supply flag
      wdt();
      rd(`RCR_ADDR_CAUSE, 8'h11);
      // Interrupt mode: no reset, the low flag drives the request
      wr(`RCR_ADDR_MON_CTRL, 8'h80);
      supply = 16'd2300;
      cyc(8);
      chk("irq", {7'h00, SUPPLY_LOW_IRQ}, 8'h01);
      chk("no reset", {7'h00, INT_RESET_N}, 8'h01);
      rd(`RCR_ADDR_MON_CTRL, 8'h81);
      rd(`RCR_ADDR_CAUSE, 8'h00);
      wr(`RCR_ADDR_MON_CTRL, 8'h00);
      cyc(2);
      chk("irq off", {7'h00, SUPPLY_LOW_IRQ}, 8'h00);
      supply = 16'd5000;
      // Reset pin clears a pending flag
      wdt();
      EXT_RESET_N = 1'b0;
      lo();
      cyc(4);
      EXT_RESET_N = 1'b1;
      rel();
      rd(`RCR_ADDR_CAUSE, 8'h00);
      // Supply dip under the power-on threshold clears it too
      wdt();
      supply = 16'd1500;
      lo();
      cyc(20);
      chk("poc hold", {7'h00, INT_RESET_N}, 8'h00);
      supply = 16'd5000;
      rel();
      rd(`RCR_ADDR_CAUSE, 8'h00);
      end_sim();
   end
endmodule : rcr_recorder_tb_top
`default_nettype wire
